// ### src/ftet_apb_regs.sv
// APB register file of the frame timing block
`timescale 1ns/1ps
`default_nettype none
module ftet_apb_regs
  import ftet_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`FTET_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output ftet_cfg_t o_cfg,
  input wire ftet_stat_t i_stat
);
  logic [31:0] ctrl_r, rows_r, active_r, rowclk_r, lineclk_r, extra_r;
  logic [31:0] rd_val;
  logic mapped, wr;

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] s, input logic [31:0] m);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r & m;
  endfunction

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (i_paddr)
      `FTET_OFF_CTRL: rd_val = ctrl_r;
      `FTET_OFF_ROWS: rd_val = rows_r;
      `FTET_OFF_ACTIVE: rd_val = active_r;
      `FTET_OFF_ROWCLK: rd_val = rowclk_r;
      `FTET_OFF_LINECLK: rd_val = lineclk_r;
      `FTET_OFF_EXTRA: rd_val = extra_r;
      `FTET_OFF_STATUS: rd_val = {i_stat.row, 12'h000, i_stat.clamped,
          i_stat.fvalid, i_stat.waiting, i_stat.armed};
      `FTET_OFF_FRAMES: rd_val = {16'h0000, i_stat.frames};
      default: mapped = 1'b0;
    endcase
  end

  assign wr = i_psel & i_penable & i_pwrite & mapped;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;

  // Captured in the setup cycle so read data comes from a flop
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) o_prdata <= 32'h0000_0000;
    else if (i_psel & ~i_penable & ~i_pwrite) o_prdata <= rd_val;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_r <= `FTET_RST_CTRL;
      rows_r <= `FTET_RST_ROWS;
      active_r <= `FTET_RST_ACTIVE;
      rowclk_r <= `FTET_RST_ROWCLK;
      lineclk_r <= `FTET_RST_LINECLK;
      extra_r <= `FTET_RST_EXTRA;
    end else if (wr) begin
      unique case (i_paddr)
        `FTET_OFF_CTRL: ctrl_r <= merge(ctrl_r, i_pwdata, i_pstrb,
            `FTET_CTRL_MASK);
        `FTET_OFF_ROWS: rows_r <= merge(rows_r, i_pwdata, i_pstrb,
            `FTET_HALF_MASK);
        `FTET_OFF_ACTIVE: active_r <= merge(active_r, i_pwdata, i_pstrb,
            `FTET_HALF_MASK);
        `FTET_OFF_ROWCLK: rowclk_r <= merge(rowclk_r, i_pwdata, i_pstrb,
            `FTET_HALF_MASK);
        `FTET_OFF_LINECLK: lineclk_r <= merge(lineclk_r, i_pwdata,
            i_pstrb, `FTET_HALF_MASK);
        `FTET_OFF_EXTRA: extra_r <= merge(extra_r, i_pwdata, i_pstrb,
            `FTET_HALF_MASK);
        default: ;
      endcase
    end
  end

  always_comb begin
    o_cfg.pin_en = ctrl_r[`FTET_CTRL_PIN_EN];
    o_cfg.ext_mode = ctrl_r[`FTET_CTRL_EXT];
    o_cfg.embed_en = ctrl_r[`FTET_CTRL_EMBED];
    o_cfg.proto = ftet_proto_t'(ctrl_r[`FTET_CTRL_PROTO_HI:
        `FTET_CTRL_PROTO_LO]);
    o_cfg.dark_code = ctrl_r[`FTET_CTRL_DARK_HI:`FTET_CTRL_DARK_LO];
    o_cfg.rows = rows_r[15:0];
    o_cfg.active = active_r[15:0];
    o_cfg.row_clks = rowclk_r[15:0];
    o_cfg.line_clks = lineclk_r[15:0];
    o_cfg.extra = extra_r[15:0];
  end
endmodule
`default_nettype wire

// ### src/ftet_frame_timing.sv
// Frame timing controller with external frame trigger
`timescale 1ns/1ps
`default_nettype none
`include "ftet_regs.svh"

// How it works
// - Frame spans rows_per_frame row periods, stretched to active rows plus minimum blanking if shorter
// - Minimum blanking: dark rows plus four
// - Dark row code 8, 4 or 2
// - Embedded data rows when enable set
// - Blank rows replace embedded rows otherwise
// - Embedded rows marked for CSI-2 layout
// - Trigger mode needs both enable bits
// - Free run: next frame after extra delay
// - Start only on armed rising trigger edge
// - Disarmed for frame period minus 16
// - Rearm after the inactive interval
// - Pointers pause while waiting for trigger
// - Edges while disarmed are ignored
// - Blanking rows first, then active rows
// - Frame starts blanking, ends last active row
// - Streaming S and SP sync code sets
// - Packetized and MIPI codes, parallel valids
// - Row lasts clocks_per_row clocks
// - Extra delay clocks after last row
module ftet_frame_timing
  import ftet_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [`FTET_ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_FRAME_TRIGGER,
  output logic O_FRAME_VALID,
  output logic O_LINE_VALID,
  output ftet_sync_t O_SYNC,
  output ftet_kind_t O_ROW_KIND,
  output logic O_EMBED_LINE,
  output logic [15:0] O_ROW_INDEX,
  output logic O_PTR_RUN
);

  typedef enum logic [1:0] {
    ST_WAIT,
    ST_ROWS,
    ST_EXTRA
  } ftet_state_t;

  ftet_cfg_t cfg;
  ftet_cfg_t lat_r;
  ftet_stat_t stat;
  ftet_state_t state_r, state_nxt;

  logic [15:0] live_min, live_rows;
  logic [16:0] live_need;
  logic live_clamp;
  logic [31:0] live_prod;
  logic [32:0] frame_clks, guard_load;

  logic [15:0] lat_rows_r, lat_dark_r, lat_vb_r;
  logic [15:0] row_r, col_r, xtra_r, frames_r;
  logic col_end, line_end, last_row, xtra_done, end_now;
  logic go, start, consume;

  logic trig_s, trig_d_r, trig_edge;
  logic ext_en, ext_d_r, ext_rise;
  logic armed_r, pend_r, accept;
  logic [32:0] inact_r;

  ftet_kind_t kind;
  logic in_rows, is_active, use_sov, use_sof, use_soa, use_end;
  ftet_sync_t sync_nxt;

  ftet_apb_regs u_regs (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RST_N),
    .i_psel(I_PSEL),
    .i_penable(I_PENABLE),
    .i_pwrite(I_PWRITE),
    .i_paddr(I_PADDR),
    .i_pwdata(I_PWDATA),
    .i_pstrb(I_PSTRB),
    .o_prdata(O_PRDATA),
    .o_pready(O_PREADY),
    .o_pslverr(O_PSLVERR),
    .o_cfg(cfg),
    .i_stat(stat)
  );

  // The trigger pin is asynchronous to the pixel clock
  ftet_sync u_trig_sync (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RST_N),
    .i_d(I_FRAME_TRIGGER),
    .o_q(trig_s)
  );

  // Live geometry; a too short frame is stretched to the minimum
  assign live_min = ftet_min_blank(cfg.dark_code);
  assign live_need = {1'b0, cfg.active} + {1'b0, live_min};
  assign live_clamp = live_need > {1'b0, cfg.rows};
  assign live_rows = live_clamp ? live_need[15:0] : cfg.rows;
  assign live_prod = 32'(live_rows) * 32'(cfg.row_clks);
  assign frame_clks = {1'b0, live_prod} + {17'h0_0000, cfg.extra};
  assign guard_load = (frame_clks > `FTET_TRIG_GUARD) ?
      frame_clks - `FTET_TRIG_GUARD : 33'h0_0000_0001;

  assign ext_en = cfg.pin_en & cfg.ext_mode;
  assign ext_rise = ext_en & ~ext_d_r;
  assign trig_edge = trig_s & ~trig_d_r;
  assign accept = ext_en & armed_r & trig_edge;

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      trig_d_r <= 1'b0;
      ext_d_r <= 1'b0;
    end else begin
      trig_d_r <= trig_s;
      ext_d_r <= ext_en;
    end
  end

  // Trigger arming; armed state can precede frame end by 16 clocks
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      armed_r <= 1'b1;
      inact_r <= 33'h0_0000_0000;
    end else if (accept) begin
      // Taken first so an edge in the enabling clock still disarms
      armed_r <= 1'b0;
      inact_r <= guard_load;
    end else if (!ext_en || ext_rise) begin
      armed_r <= 1'b1;
      inact_r <= 33'h0_0000_0000;
    end else if (!armed_r) begin
      if (inact_r <= 33'h0_0000_0001) begin
        armed_r <= 1'b1;
      end else begin
        inact_r <= inact_r - 33'h0_0000_0001;
      end
    end
  end

  // An edge taken before the readout ends waits here for the frame end
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      pend_r <= 1'b0;
    end else if (!ext_en) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= accept | (pend_r & ~consume);
    end
  end

  // True on the last count of a span; a zero span ends at once
  function automatic logic at_last(input logic [15:0] cur,
      input logic [15:0] lim);
    return ({1'b0, cur} + 17'h0_0001) >= {1'b0, lim};
  endfunction

  // Row and frame position against the settings of this frame
  assign col_end = at_last(col_r, lat_r.row_clks);
  assign line_end = ({1'b0, col_r} + 17'h0_0001) ==
      {1'b0, lat_r.line_clks};
  assign last_row = at_last(row_r, lat_rows_r);
  assign xtra_done = at_last(xtra_r, lat_r.extra);
  assign end_now = (state_r == ST_ROWS && col_end && last_row &&
      lat_r.extra == 16'h0000) || (state_r == ST_EXTRA && xtra_done);

  assign go = ~ext_en | pend_r;
  assign start = ((state_r == ST_WAIT) | end_now) & go;
  assign consume = start & ext_en;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_WAIT: begin
        if (start) state_nxt = ST_ROWS;
      end
      ST_ROWS: begin
        if (col_end && last_row) begin
          if (lat_r.extra != 16'h0000) state_nxt = ST_EXTRA;
          else state_nxt = start ? ST_ROWS : ST_WAIT;
        end
      end
      ST_EXTRA: begin
        if (xtra_done) state_nxt = start ? ST_ROWS : ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) state_r <= ST_WAIT;
    else state_r <= state_nxt;
  end

  // Settings are taken once per frame so a frame is never torn
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      lat_r <= '0;
      lat_rows_r <= 16'h0000;
      lat_dark_r <= 16'h0000;
      lat_vb_r <= 16'h0000;
    end else if (start) begin
      lat_r <= cfg;
      lat_rows_r <= live_rows;
      lat_dark_r <= ftet_dark_rows(cfg.dark_code);
      lat_vb_r <= live_rows - cfg.active;
    end
  end

  // Frame count for software; wraps silently
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      frames_r <= 16'h0000;
    end else if (start) begin
      frames_r <= frames_r + 16'h0001;
    end
  end

  // Column within the row; a zero row length counts as one clock
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      col_r <= 16'h0000;
    end else if (start) begin
      col_r <= 16'h0000;
    end else if (state_r == ST_ROWS) begin
      col_r <= col_end ? 16'h0000 : col_r + 16'h0001;
    end
  end

  // Row pointer; holds the last row through extra delay and waiting
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      row_r <= 16'h0000;
    end else if (start) begin
      row_r <= 16'h0000;
    end else if (state_r == ST_ROWS && col_end && !last_row) begin
      row_r <= row_r + 16'h0001;
    end
  end

  // Extra delay clocks after the last row
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      xtra_r <= 16'h0000;
    end else if (start) begin
      xtra_r <= 16'h0000;
    end else if (state_r == ST_EXTRA) begin
      xtra_r <= xtra_r + 16'h0001;
    end
  end

  // Blanking rows lead: dark, embedded or blank pair, then blank
  always_comb begin
    if (row_r < lat_dark_r) begin
      kind = FTET_ROW_DARK;
    end else if (row_r < lat_dark_r + `FTET_EMBED_ROWS) begin
      kind = lat_r.embed_en ? FTET_ROW_EMBED : FTET_ROW_BLANK;
    end else if (row_r < lat_vb_r) begin
      kind = FTET_ROW_BLANK;
    end else begin
      kind = FTET_ROW_ACTIVE;
    end
  end

  // Codes and valids only while rows are read, never in extra delay
  assign in_rows = state_r == ST_ROWS;
  assign is_active = in_rows && kind == FTET_ROW_ACTIVE;

  // Code sets per protocol; parallel relies on the valid flags alone
  assign use_sov = lat_r.proto == FTET_PROTO_SS ||
      lat_r.proto == FTET_PROTO_SSP;
  assign use_sof = lat_r.proto == FTET_PROTO_SSP ||
      lat_r.proto == FTET_PROTO_PSP ||
      lat_r.proto == FTET_PROTO_MIPI;
  assign use_soa = use_sov | use_sof;
  assign use_end = use_sof;

  always_comb begin
    sync_nxt = '0;
    if (in_rows && col_r == 16'h0000) begin
      sync_nxt.start_vblank_row = use_sov && !is_active;
      sync_nxt.sof = use_sof && row_r == 16'h0000;
      sync_nxt.start_active_line = use_soa && is_active;
    end
    if (is_active && line_end) begin
      sync_nxt.end_of_line = use_end;
      sync_nxt.eof = use_end && last_row;
    end
  end

  // Registered framing flags, one clock behind the counters
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_FRAME_VALID <= 1'b0;
      O_LINE_VALID <= 1'b0;
      O_SYNC <= '0;
    end else begin
      O_FRAME_VALID <= is_active;
      O_LINE_VALID <= is_active && col_r < lat_r.line_clks;
      O_SYNC <= sync_nxt;
    end
  end

  // Row description, aligned with the framing flags
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_ROW_KIND <= FTET_ROW_BLANK;
      O_EMBED_LINE <= 1'b0;
      O_ROW_INDEX <= 16'h0000;
    end else begin
      O_ROW_KIND <= kind;
      // Second of the two embedded rows for the CSI-2 packer
      O_EMBED_LINE <= row_r != lat_dark_r;
      O_ROW_INDEX <= row_r;
    end
  end

  // Shutter and read pointers stand still while awaiting a trigger
  assign O_PTR_RUN = state_r != ST_WAIT;

  // Status view; armed reads low whenever trigger mode is off
  always_comb begin
    stat.armed = ext_en & armed_r;
    stat.waiting = state_r == ST_WAIT;
    stat.fvalid = is_active;
    stat.clamped = live_clamp;
    stat.row = row_r;
    stat.frames = frames_r;
  end

endmodule
`default_nettype wire

// ### src/ftet_pkg.sv
// Types and helper functions of the frame timing block
`include "ftet_regs.svh"
package ftet_pkg;

  typedef enum logic [2:0] {
    FTET_PROTO_PAR,
    FTET_PROTO_SS,
    FTET_PROTO_SSP,
    FTET_PROTO_PSP,
    FTET_PROTO_MIPI
  } ftet_proto_t;

  typedef enum logic [1:0] {
    FTET_ROW_DARK,
    FTET_ROW_EMBED,
    FTET_ROW_BLANK,
    FTET_ROW_ACTIVE
  } ftet_kind_t;

  typedef struct packed {
    logic pin_en;
    logic ext_mode;
    logic embed_en;
    ftet_proto_t proto;
    logic [3:0] dark_code;
    logic [15:0] rows;
    logic [15:0] active;
    logic [15:0] row_clks;
    logic [15:0] line_clks;
    logic [15:0] extra;
  } ftet_cfg_t;

  typedef struct packed {
    logic armed;
    logic waiting;
    logic fvalid;
    logic clamped;
    logic [15:0] row;
    logic [15:0] frames;
  } ftet_stat_t;

  typedef struct packed {
    logic start_vblank_row;
    logic sof;
    logic start_active_line;
    logic end_of_line;
    logic eof;
  } ftet_sync_t;

  // Unsupported codes fall back to the reset count
  function automatic logic [15:0] ftet_dark_rows(input logic [3:0] code);
    unique case (code)
      `FTET_DARK_4: return {12'h000, `FTET_DARK_4};
      `FTET_DARK_2: return {12'h000, `FTET_DARK_2};
      default: return {12'h000, `FTET_DARK_8};
    endcase
  endfunction

  function automatic logic [15:0] ftet_min_blank(input logic [3:0] code);
    return ftet_dark_rows(code) + `FTET_EMBED_ROWS + `FTET_BLANK_ROWS;
  endfunction

endpackage

// ### src/ftet_regs.svh
// Register map, field positions, reset values and timing constants
`ifndef FTET_REGS_SVH
`define FTET_REGS_SVH

`define FTET_ADDR_W 8
`define FTET_OFF_CTRL 8'h00
`define FTET_OFF_ROWS 8'h04
`define FTET_OFF_ACTIVE 8'h08
`define FTET_OFF_ROWCLK 8'h0C
`define FTET_OFF_LINECLK 8'h10
`define FTET_OFF_EXTRA 8'h14
`define FTET_OFF_STATUS 8'h18
`define FTET_OFF_FRAMES 8'h1C

`define FTET_CTRL_PIN_EN 0
`define FTET_CTRL_EXT 1
`define FTET_CTRL_EMBED 2
`define FTET_CTRL_PROTO_LO 4
`define FTET_CTRL_PROTO_HI 6
`define FTET_CTRL_DARK_LO 8
`define FTET_CTRL_DARK_HI 11
`define FTET_CTRL_MASK 32'h0000_0F77
`define FTET_HALF_MASK 32'h0000_FFFF

`define FTET_RST_CTRL 32'h0000_0804
`define FTET_RST_ROWS 32'h0000_0020
`define FTET_RST_ACTIVE 32'h0000_0010
`define FTET_RST_ROWCLK 32'h0000_0040
`define FTET_RST_LINECLK 32'h0000_0030
`define FTET_RST_EXTRA 32'h0000_0000

`define FTET_DARK_8 4'h8
`define FTET_DARK_4 4'h4
`define FTET_DARK_2 4'h2
`define FTET_EMBED_ROWS 16'h0002
`define FTET_BLANK_ROWS 16'h0002
`define FTET_TRIG_GUARD 33'h0_0000_0010

`endif

// ### src/ftet_sync.sv
// Two-stage synchroniser for the trigger pin
`timescale 1ns/1ps
`default_nettype none
module ftet_sync (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_d,
  output logic o_q
);
  logic meta_r;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_r <= 1'b0;
      o_q <= 1'b0;
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ### verification/ftet_frame_timing_assertions.sv
// Concurrent checks on the frame timing block ports
`timescale 1ns/1ps
`default_nettype none
module ftet_frame_timing_assertions
  import ftet_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic I_FRAME_TRIGGER,
  input wire logic O_FRAME_VALID,
  input wire logic O_LINE_VALID,
  input wire ftet_sync_t O_SYNC,
  input wire ftet_kind_t O_ROW_KIND,
  input wire logic O_PTR_RUN
);
  logic trig_d_r;
  logic [3:0] since_trig_r;
  logic [3:0] since_rst_r;

  always_ff @(posedge I_REF_CLK) begin
    trig_d_r <= I_FRAME_TRIGGER;
  end

  // Saturating ages keep the pause check bounded
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      since_trig_r <= 4'hF;
    end else if (I_FRAME_TRIGGER && !trig_d_r) begin
      since_trig_r <= 4'h0;
    end else if (since_trig_r != 4'hF) begin
      since_trig_r <= since_trig_r + 4'h1;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      since_rst_r <= 4'h0;
    end else if (since_rst_r != 4'hF) begin
      since_rst_r <= since_rst_r + 4'h1;
    end
  end

  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RST_N);

  sequence line_end_s;
    O_LINE_VALID ##1 !O_LINE_VALID;
  endsequence

  sequence trig_wait_s;
    !O_PTR_RUN && $rose(I_FRAME_TRIGGER);
  endsequence

  lv_in_frame_a: assert property (
    O_LINE_VALID |-> O_FRAME_VALID && O_ROW_KIND == FTET_ROW_ACTIVE)
    else $error("line valid outside an active row");
  fv_active_a: assert property (
    O_FRAME_VALID |-> O_ROW_KIND == FTET_ROW_ACTIVE)
    else $error("frame valid on a blanking row");
  line_end_a: assert property (O_SYNC.end_of_line |-> line_end_s)
    else $error("end of line not at last line valid clock");
  eof_on_eol_a: assert property (
    O_SYNC.eof |-> O_SYNC.end_of_line && O_FRAME_VALID)
    else $error("end of frame not on last line end");
  soa_active_a: assert property (
    O_SYNC.start_active_line |-> O_ROW_KIND == FTET_ROW_ACTIVE && !O_SYNC.start_vblank_row)
    else $error("start of active line on wrong row");
  sov_vblank_a: assert property (
    O_SYNC.start_vblank_row |-> O_ROW_KIND != FTET_ROW_ACTIVE && !O_FRAME_VALID)
    else $error("vertical blanking code on active row");
  sof_dark_a: assert property (
    O_SYNC.sof |-> O_ROW_KIND == FTET_ROW_DARK)
    else $error("start of frame not on first blanking row");
  blank_first_a: assert property (
    $rose(O_ROW_KIND == FTET_ROW_ACTIVE) |->
      $past(O_ROW_KIND) == FTET_ROW_BLANK)
    else $error("active rows not preceded by blank rows");
  trig_start_a: assert property (trig_wait_s |-> ##[1:6] O_PTR_RUN)
    else $error("armed trigger edge did not start readout");
  pause_hold_a: assert property (
    $rose(O_PTR_RUN) |-> since_rst_r < 4'h4 || since_trig_r < 4'h8)
    else $error("pointers resumed without a trigger edge");
endmodule
bind ftet_frame_timing ftet_frame_timing_assertions u_chk (
  .I_REF_CLK(I_REF_CLK),
  .I_RST_N(I_RST_N),
  .I_FRAME_TRIGGER(I_FRAME_TRIGGER),
  .O_FRAME_VALID(O_FRAME_VALID),
  .O_LINE_VALID(O_LINE_VALID),
  .O_SYNC(O_SYNC),
  .O_ROW_KIND(O_ROW_KIND),
  .O_PTR_RUN(O_PTR_RUN)
);
`default_nettype wire

// ### verification/ftet_host_model.sv
// Host side model that drives frame trigger pulses
`timescale 1ns/1ps
`default_nettype none
module ftet_host_model #(
  parameter int HOLD = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_fire,
  output logic o_trigger
);
  logic [7:0] hold_r;

  // Pulse held several clocks so the pin synchroniser cannot miss it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      hold_r <= 8'h00;
    end else if (i_fire) begin
      hold_r <= HOLD[7:0];
    end else if (hold_r != 8'h00) begin
      hold_r <= hold_r - 8'h01;
    end
  end

  assign o_trigger = (hold_r != 8'h00);
endmodule
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the frame timing block
`timescale 1ns/1ps
`default_nettype none
`include "ftet_regs.svh"
module tb
  import ftet_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic fire = 1'b0;
  logic trig;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fvalid;
  logic lvalid;
  ftet_sync_t sync;
  ftet_kind_t row_kind;
  logic emb_line;
  logic [15:0] row_idx;
  logic ptr_run;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int cmp_count = 0;
  int m_tot, m_dark, m_emb, m_fv, m_lv, m_e0, m_ri;
  int m_sync [5];
  int t_proto [5] = '{2, 1, 3, 4, 0};
  int t_dark [5] = '{8, 4, 2, 8, 4};
  int t_emb [5] = '{1, 0, 1, 0, 1};
  int t_rows [5] = '{20, 20, 3, 18, 20};
  logic [31:0] rst_v [6] = '{`FTET_RST_CTRL, `FTET_RST_ROWS,
    `FTET_RST_ACTIVE, `FTET_RST_ROWCLK, `FTET_RST_LINECLK, `FTET_RST_EXTRA};

  ftet_frame_timing u_ftet_frame_timing (
    .I_REF_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_FRAME_TRIGGER(trig), .O_FRAME_VALID(fvalid), .O_LINE_VALID(lvalid),
    .O_SYNC(sync), .O_ROW_KIND(row_kind), .O_EMBED_LINE(emb_line),
    .O_ROW_INDEX(row_idx), .O_PTR_RUN(ptr_run)
  );

  ftet_host_model u_ftet_host_model (
    .i_clk(clk), .i_rst_n(rst_n), .i_fire(fire), .o_trigger(trig)
  );

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Holds the request until pready is sampled; no wait count assumed
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic pulse();
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask

  task automatic wait_run(input logic v, input int lim, input string name);
    int n;
    n = 0;
    while (ptr_run !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    check(name, ptr_run, v);
  endtask

  // One frame is the span between two entries into the dark rows;
  // the first frame seen may still carry the settings before a write
  task automatic measure();
    ftet_kind_t last;
    int n;
    last = row_kind;
    n = 0;
    m_tot = 0;
    m_dark = 0;
    m_emb = 0;
    m_fv = 0;
    m_lv = 0;
    m_e0 = 0;
    m_ri = 0;
    m_sync = '{default: 0};
    for (int c = 0; c < 3000 && n < 3; c++) begin
      @(posedge clk);
      if (row_kind === FTET_ROW_DARK && last !== FTET_ROW_DARK) n++;
      last = row_kind;
      if (n == 2) begin
        m_tot++;
        m_dark += (row_kind === FTET_ROW_DARK);
        m_emb += (row_kind === FTET_ROW_EMBED);
        m_fv += (fvalid === 1'b1);
        m_lv += (lvalid === 1'b1);
        for (int b = 0; b < 5; b++) m_sync[b] += (sync[b] === 1'b1);
        m_e0 += (row_kind === FTET_ROW_EMBED && emb_line === 1'b0);
        if (row_idx > m_ri) m_ri = row_idx;
      end
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    forever #2 clk = ~clk;
  end

  initial begin
    #80000;
    miscompares++;
    end_sim();
  end

  initial begin
    int eff;
    int ser;
    int lows;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0, rd, err);
      check("reset value", rd, rst_v[i]);
    end
    apb(1'b0, 8'h20, 32'h0, rd, err);
    check("unmapped error", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    wr(8'h08, 32'h4);
    wr(8'h0C, 32'h8);
    wr(8'h10, 32'h5);
    wr(8'h14, 32'h3);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      wr(8'h04, 32'(t_rows[i]));
      wr(8'h00, {20'h0, 4'(t_dark[i]), 1'b0, 3'(t_proto[i]), 1'b0,
                 1'(t_emb[i]), 2'b00});
      measure();
      eff = (t_rows[i] > 8 + t_dark[i]) ? t_rows[i] : 8 + t_dark[i];
      ser = (t_proto[i] >= 2);
      check("frame clocks", m_tot, eff * 8 + 3);
      check("dark clocks", m_dark, t_dark[i] * 8);
      check("embed clocks", m_emb, t_emb[i] * 16);
      check("blank clocks", m_tot - m_dark - m_emb - m_fv,
            (eff - 4 - t_dark[i] - 2 * t_emb[i]) * 8 + 3);
      check("frame valid clocks", m_fv, 32);
      check("line valid clocks", m_lv, 20);
      check("sov count", m_sync[4],
            (t_proto[i] == 1 || t_proto[i] == 2) ? eff - 4 : 0);
      check("sof count", m_sync[3], ser);
      check("soa count", m_sync[2], (t_proto[i] != 0) ? 4 : 0);
      check("eol count", m_sync[1], ser * 4);
      check("eof count", m_sync[0], ser);
      check("embed first row", m_e0, t_emb[i] * 8);
      check("last row index", m_ri, eff - 1);
      apb(1'b0, 8'h18, 32'h0, rd, err);
      check("rows clamped", rd[3], t_rows[i] < 8 + t_dark[i]);
    end
    $display("test frame layout done");
    wr(8'h00, 32'h0000_0405);
    measure();
    check("free run frame", m_tot, 163);
    wr(8'h00, 32'h0000_0407);
    apb(1'b0, 8'h18, 32'h0, rd, err);
    check("armed on enable", rd[0], 1'b1);
    wait_run(1'b0, 400, "paused");
    repeat (40) @(posedge clk);
    check("no start unprompted", ptr_run, 1'b0);
    pulse();
    wait_run(1'b1, 8, "trigger start");
    repeat (60) @(posedge clk);
    apb(1'b0, 8'h18, 32'h0, rd, err);
    check("disarmed", rd[0], 1'b0);
    // Edge sent too early on purpose: must be dropped
    pulse();
    wait_run(1'b0, 300, "frame end");
    repeat (40) @(posedge clk);
    check("early edge ignored", ptr_run, 1'b0);
    apb(1'b0, 8'h18, 32'h0, rd, err);
    check("rearmed", rd[0], 1'b1);
    pulse();
    wait_run(1'b1, 8, "next start");
    // Edge in the last clocks of a 163 clock frame pends to its end
    repeat (150) @(posedge clk);
    pulse();
    lows = 0;
    repeat (40) begin
      @(posedge clk);
      lows += (ptr_run !== 1'b1);
    end
    check("back to back start", lows, 0);
    $display("test trigger done");
    end_sim();
  end
endmodule
`default_nettype wire
